// *** logic/smcd_params.svh ***
// constants for the servo move command decoder
// assumes a single 100 MHz clock domain
`ifndef SMCD_PARAMS_SVH
`define SMCD_PARAMS_SVH
`define SMCD_B0_START_BIT   0
`define SMCD_B0_SERVO_BIT   1
`define SMCD_B2_HOME_BIT    7
`define SMCD_B3_INC_BIT     0
`define SMCD_CODE_LSB       0
`define SMCD_CODE_MSB       3
`define SMCD_CODE_NONE      4'h0
`define SMCD_CODE_DIRECT    4'h1
`define SMCD_CODE_INTFEED   4'h2
`define SMCD_CODE_NOTCH     4'h3
`define SMCD_POS_RESET      32'h0000_0000
`define SMCD_MODE_RESET     3'h0
`endif

// *** logic/smcd_pkg.sv ***
// types for the servo move command decoder
// assumes smcd_params.svh is on the include path
package smcd_pkg;
    typedef enum logic [2:0] {
        SMCD_IDLE,
        SMCD_HOME,
        SMCD_MOVE,
        SMCD_INTMOVE,
        SMCD_NOTCHMOVE
    } smcd_state_t;
endpackage

// *** logic/smcd_decoder.sv ***
// servo move command decoder: takes the eight-byte command frame, starts motions
// assumes frame bytes and motion status come from logic on the same clock
// Behaviour
// - Byte 2 bit 7 with servo enable set requests an origin search in the set mode.
// - An accepted origin search runs the procedure of the configured search mode.
// - A code-selected move starts only on a 0 to 1 change of byte 0 bit 0.
// - Byte 3 bit 0 selects relative target (present plus commanded) or absolute.
// - Code 1 moves the axis to the commanded target.
// - Code 2 feeds toward target and on interrupt change slows and runs a set distance.
// - Interrupt feeding uses the ordinary positioning acceleration settings.
// - Code 3 moves to target and pulses one of two notch outputs on passing a set point.
`timescale 1ns/10ps
`include "smcd_params.svh"
module smcd_decoder
    import smcd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  cmdByte0,
    input  wire logic [7:0]  cmdByte1,
    input  wire logic [7:0]  cmdByte2,
    input  wire logic [7:0]  cmdByte3,
    input  wire logic [31:0] cmdTarget,
    input  wire logic [31:0] presentPos,
    input  wire logic [2:0]  homeModeCfg,
    input  wire logic [31:0] notch1Pos,
    input  wire logic [31:0] notch2Pos,
    input  wire logic [31:0] intDistance,
    input  wire logic        intInput,
    input  wire logic        motionDone,
    output logic             servoOn,
    output logic             homeStart,
    output logic [2:0]       homeMode,
    output logic             moveStart,
    output logic [31:0]      moveTarget,
    output logic             intSlowStart,
    output logic             useMainAccel,
    output logic             notch1Out,
    output logic             notch2Out,
    output logic             busy
);

    ////////////////////////////////////////////////////////////////
    // decode
    smcd_state_t state_q;
    smcd_state_t state_d;
    logic        startPrev_q;
    logic        intSync1_q;
    logic        intSync2_q;
    logic        intPrev_q;
    logic [31:0] origin_q;
    logic        servoOn_q;
    logic        homeStart_q;
    logic        moveStart_q;
    logic        intSlowStart_q;
    logic        notch1_q;
    logic        notch2_q;
    logic        useMainAccel_q;
    logic        busy_q;
    logic [2:0]  homeMode_q;
    logic [31:0] moveTarget_q;

    // true when position p lies between from and to, either direction
    function automatic logic passed(input logic [31:0] p, input logic [31:0] a,
                                    input logic [31:0] b);
        passed = ($signed(a) <= $signed(p) && $signed(p) <= $signed(b)) ||
                 ($signed(b) <= $signed(p) && $signed(p) <= $signed(a));
    endfunction

    wire        servoReq  = cmdByte0[`SMCD_B0_SERVO_BIT];
    wire        startBit  = cmdByte0[`SMCD_B0_START_BIT];
    wire        startEdge = startBit & ~startPrev_q;
    wire        homeReq   = cmdByte2[`SMCD_B2_HOME_BIT] & servoReq;
    wire [3:0]  code      = cmdByte1[`SMCD_CODE_MSB:`SMCD_CODE_LSB];
    wire        relMode   = cmdByte3[`SMCD_B3_INC_BIT];
    // relative target adds present position; wraps like the counter it feeds
    wire [31:0] tgtCalc   = relMode ? presentPos + cmdTarget : cmdTarget;
    wire        idle      = (state_q == SMCD_IDLE);
    wire        goMove    = idle & servoReq & startEdge & ~homeReq;
    wire        intEdge   = intSync2_q ^ intPrev_q; // any change of state
    wire        intHit    = (state_q == SMCD_INTMOVE) & intEdge;
    wire        inNotch   = (state_q == SMCD_NOTCHMOVE);
    wire [31:0] intTarget = presentPos + intDistance;

    ////////////////////////////////////////////////////////////////
    // next values of the registered outputs
    wire        homeStart_d    = homeReq & idle;
    // a start edge with an unknown code leaves the state idle: no pulse
    wire        moveStart_d    = goMove & (state_d != SMCD_IDLE);
    wire        intSlowStart_d = intHit & ~motionDone & servoReq;
    // same accel/decel set for direct, interrupt and notch moves
    wire        useMainAccel_d = (state_d != SMCD_IDLE) & (state_d != SMCD_HOME);
    // busy is a flop of its own so the port has no decode glitch
    wire        busy_d         = (state_d != SMCD_IDLE);
    wire [2:0]  homeMode_d     = homeStart_d ? homeModeCfg : homeMode_q;
    // a new move loads the commanded target, an interrupt reloads from here
    wire [31:0] moveTarget_d   = goMove ? tgtCalc : intHit ? intTarget : moveTarget_q;
    // notch test looks back one cycle, so fast travel cannot jump a point
    wire        notch1_d       = inNotch & passed(notch1Pos, origin_q, presentPos);
    wire        notch2_d       = inNotch & passed(notch2Pos, origin_q, presentPos);

    ////////////////////////////////////////////////////////////////
    // sequencing
    // home outranks a start seen in the same cycle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SMCD_IDLE: begin
                if (homeReq & idle) begin
                    state_d = SMCD_HOME;
                end else if (goMove) begin
                    if (code == `SMCD_CODE_DIRECT) begin
                        state_d = SMCD_MOVE;
                    end else if (code == `SMCD_CODE_INTFEED) begin
                        state_d = SMCD_INTMOVE;
                    end else if (code == `SMCD_CODE_NOTCH) begin
                        state_d = SMCD_NOTCHMOVE;
                    end
                end
            end
            SMCD_HOME, SMCD_MOVE, SMCD_INTMOVE, SMCD_NOTCHMOVE: begin
                // dropping servo enable abandons the motion
                if (motionDone | ~servoReq) begin
                    state_d = SMCD_IDLE;
                end else if (intHit) begin
                    state_d = SMCD_MOVE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // state and edge history
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q     <= SMCD_IDLE;
            startPrev_q <= 1'b1; // a start held high through reset is no edge
            origin_q    <= `SMCD_POS_RESET;
        end else begin
            state_q     <= state_d;
            startPrev_q <= startBit;
            origin_q    <= presentPos;
        end
    end

    // interrupt pin is asynchronous: two flops before any logic reads it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            intSync1_q <= 1'b0;
            intSync2_q <= 1'b0;
            intPrev_q  <= 1'b0;
        end else begin
            intSync1_q <= intInput;
            intSync2_q <= intSync1_q;
            intPrev_q  <= intSync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one-cycle start pulses
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            homeStart_q    <= 1'b0;
            moveStart_q    <= 1'b0;
            intSlowStart_q <= 1'b0;
        end else begin
            homeStart_q    <= homeStart_d;
            moveStart_q    <= moveStart_d;
            intSlowStart_q <= intSlowStart_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // levels handed to the motion generator
    // mode is taken at acceptance; later changes wait for the next search
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            servoOn_q      <= 1'b0;
            useMainAccel_q <= 1'b0;
            busy_q         <= 1'b0;
            homeMode_q     <= `SMCD_MODE_RESET;
            moveTarget_q   <= `SMCD_POS_RESET;
        end else begin
            servoOn_q      <= servoReq;
            useMainAccel_q <= useMainAccel_d;
            busy_q         <= busy_d;
            homeMode_q     <= homeMode_d;
            moveTarget_q   <= moveTarget_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // notch outputs, high in each cycle a notch point is crossed
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            notch1_q <= 1'b0;
            notch2_q <= 1'b0;
        end else begin
            notch1_q <= notch1_d;
            notch2_q <= notch2_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign servoOn      = servoOn_q;
    assign homeStart    = homeStart_q;
    assign homeMode     = homeMode_q;
    assign moveStart    = moveStart_q;
    assign moveTarget   = moveTarget_q;
    assign intSlowStart = intSlowStart_q;
    assign useMainAccel = useMainAccel_q;
    assign notch1Out    = notch1_q;
    assign notch2Out    = notch2_q;
    assign busy         = busy_q;

endmodule // smcd_decoder

// *** tb/smcd_decoder_properties.sv ***
// assertions on the move command decoder ports
// assumes bind onto smcd_decoder, one clock
`timescale 1ns/10ps
module smcd_decoder_properties (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        servoOn,
    input wire logic        homeStart,
    input wire logic        moveStart,
    input wire logic        busy,
    input wire logic        intSlowStart,
    input wire logic        useMainAccel,
    input wire logic        notch1Out,
    input wire logic        notch2Out,
    input wire logic [7:0]  cmdByte0,
    input wire logic [7:0]  cmdByte1,
    input wire logic [7:0]  cmdByte2,
    input wire logic [7:0]  cmdByte3,
    input wire logic [2:0]  homeModeCfg,
    input wire logic [2:0]  homeMode,
    input wire logic [31:0] cmdTarget,
    input wire logic [31:0] presentPos,
    input wire logic [31:0] intDistance,
    input wire logic [31:0] moveTarget
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // home wins over start
    wire logic go = !busy && cmdByte0[1] && !cmdByte2[7]
                    && cmdByte1[3:0] inside {[4'h1:4'h3]};
    a_servo_copy: assert property (servoOn == $past(cmdByte0[1])) else $error("servo");
    a_home_take: assert property (!busy && cmdByte0[1] && cmdByte2[7]
        |=> homeStart && homeMode == $past(homeModeCfg)) else $error("home");
    a_move_edge: assert property (go && $rose(cmdByte0[0]) |=> moveStart)
        else $error("edge");
    a_edge_only: assert property (moveStart |-> !$past(cmdByte0[0], 2))
        else $error("level");
    a_target_val: assert property (moveStart |-> moveTarget == ($past(cmdByte3[0])
        ? $past(presentPos) + $past(cmdTarget) : $past(cmdTarget))) else $error("target");
    a_int_target: assert property (intSlowStart |-> useMainAccel && moveTarget ==
        $past(presentPos) + $past(intDistance)) else $error("interrupt");
    a_main_accel: assert property (moveStart |-> useMainAccel) else $error("accel");
    a_busy_refuse: assert property (busy |=> !moveStart && !homeStart)
        else $error("busy");
    // a notch may still show in the cycle the motion ends
    a_notch_move: assert property (notch1Out |-> $past(busy) && $past(useMainAccel))
        else $error("notch");
    a_notch2_move: assert property (notch2Out |-> $past(busy) && $past(useMainAccel))
        else $error("notch2");
endmodule // smcd_decoder_properties

// *** tb/smcd_master.sv ***
// master model writing the command frame
// assumes the decoder clock
`timescale 1ns/10ps
module smcd_master (
    input  wire logic   clk,
    output logic [7:0]  cmdByte0,
    output logic [7:0]  cmdByte1,
    output logic [7:0]  cmdByte2,
    output logic [7:0]  cmdByte3,
    output logic [31:0] cmdTarget
);
    initial {cmdByte0, cmdByte1, cmdByte2, cmdByte3, cmdTarget} = {32'h1010_0000, 32'h0};
    // code cleared first, start raised last
    task automatic move(input logic [3:0] c, input logic inc, input logic [31:0] t);
        @(negedge clk) cmdByte1 = 8'h10;
        cmdByte0 = 8'h12;
        @(negedge clk) {cmdByte3, cmdTarget} = {7'h0, inc, t};
        @(negedge clk) cmdByte1[3:0] = c;
        @(negedge clk) cmdByte0[0] = 1'b1;
    endtask
    task automatic rest();
        @(negedge clk) cmdByte0[0] = 1'b0;
        cmdByte2 = 8'h00;
    endtask
    task automatic home();
        @(negedge clk) {cmdByte0, cmdByte2} = 16'h1280;
    endtask
endmodule // smcd_master

// *** tb/tb.sv ***
// bench: each code, refusals, interrupt, notch, origin search
// assumes master model and checker
`timescale 1ns/10ps
module tb;
    logic        clk         = 1'b0;
    logic        reset_n     = 1'b0;
    logic        intInput    = 1'b0;
    logic        motionDone  = 1'b0;
    logic [31:0] presentPos  = 32'h0;
    logic [31:0] notch1Pos   = 32'h0;
    logic [31:0] intDistance = 32'h0;
    logic [31:0] rnd         = 32'h77de;
    logic [2:0]  homeModeCfg = 3'h0;
    logic [31:0] notch2Pos;
    logic [2:0]  homeMode;
    logic [7:0]  cmdByte0, cmdByte1, cmdByte2, cmdByte3;
    logic [31:0] cmdTarget, moveTarget;
    logic        servoOn, homeStart, moveStart, intSlowStart, useMainAccel;
    logic        notch1Out, notch2Out, busy;
    int          failCount   = 0;
    int          checks      = 0;
    // second notch sits a step block above the first
    assign notch2Pos = notch1Pos + 32'h100;
    smcd_master i_mst (
        .clk      (clk),
        .cmdByte0 (cmdByte0),
        .cmdByte1 (cmdByte1),
        .cmdByte2 (cmdByte2),
        .cmdByte3 (cmdByte3),
        .cmdTarget(cmdTarget)
    );
    smcd_decoder i_dut (
        .clk         (clk),
        .reset_n     (reset_n),
        .cmdByte0    (cmdByte0),
        .cmdByte1    (cmdByte1),
        .cmdByte2    (cmdByte2),
        .cmdByte3    (cmdByte3),
        .cmdTarget   (cmdTarget),
        .presentPos  (presentPos),
        .homeModeCfg (homeModeCfg),
        .notch1Pos   (notch1Pos),
        .notch2Pos   (notch2Pos),
        .intDistance (intDistance),
        .intInput    (intInput),
        .motionDone  (motionDone),
        .servoOn     (servoOn),
        .homeStart   (homeStart),
        .homeMode    (homeMode),
        .moveStart   (moveStart),
        .moveTarget  (moveTarget),
        .intSlowStart(intSlowStart),
        .useMainAccel(useMainAccel),
        .notch1Out   (notch1Out),
        .notch2Out   (notch2Out),
        .busy        (busy)
    );
    always #5 clk = ~clk;
    initial begin
        #20000;
        failCount++;
        closeOut();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] expT(input logic inc, input logic [31:0] p, t);
        return inc ? p + t : t;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic closeOut();
        $display("checks %0d fails %0d", checks, failCount);
        if (failCount == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        // codes 0 and f must be ignored
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            presentPos = {2'b00, rnd[31:2]};
            notch1Pos = presentPos + 32'h2;
            intDistance = rnd ^ 32'h0f0f;
            i_mst.move(k == 4 ? 4'hf : k[3:0], rnd[0], rnd);
            repeat (20) if (moveStart !== 1'b1) @(negedge clk);
            chk("moveStart", moveStart, k inside {[1:3]});
            if (k inside {[1:3]}) begin
                chk("moveTarget", moveTarget, expT(rnd[0], presentPos, rnd));
                chk("servoOn", servoOn, 1'b1);
                presentPos = presentPos + 32'h4;
                @(negedge clk);
                chk("useMainAccel", useMainAccel, 1'b1);
                chk("notch1Out", notch1Out, k == 3);
                chk("notch2Out", notch2Out, 1'b0);
                if (k == 3) begin
                    // jump past the second notch only
                    presentPos = presentPos + 32'h100;
                    @(negedge clk);
                    chk("notch1Out", notch1Out, 1'b0);
                    chk("notch2Out", notch2Out, 1'b1);
                end
                if (k == 2) begin
                    intInput = ~intInput;
                    repeat (8) if (intSlowStart !== 1'b1) @(negedge clk);
                    chk("intSlowStart", intSlowStart, 1'b1);
                    chk("intTarget", moveTarget, presentPos + intDistance);
                end
                @(negedge clk) motionDone = 1'b1;
                @(negedge clk) motionDone = 1'b0;
            end
            // start still high: a level must not restart
            repeat (3) @(negedge clk);
            chk("busy", busy, 1'b0);
            i_mst.rest();
        end
        homeModeCfg = rnd[2:0];
        i_mst.home();
        repeat (20) if (homeStart !== 1'b1) @(negedge clk);
        chk("homeStart", homeStart, 1'b1);
        chk("homeMode", homeMode, homeModeCfg);
        chk("busy", busy, 1'b1);
        chk("useMainAccel", useMainAccel, 1'b0);
        i_mst.rest();
        @(negedge clk) motionDone = 1'b1;
        @(negedge clk) motionDone = 1'b0;
        chk("busy", busy, 1'b0);
        closeOut();
    end
endmodule // tb
bind smcd_decoder smcd_decoder_properties i_chk (
    .clk         (clk),
    .reset_n     (reset_n),
    .servoOn     (servoOn),
    .homeStart   (homeStart),
    .moveStart   (moveStart),
    .busy        (busy),
    .intSlowStart(intSlowStart),
    .useMainAccel(useMainAccel),
    .notch1Out   (notch1Out),
    .notch2Out   (notch2Out),
    .cmdByte0    (cmdByte0),
    .cmdByte1    (cmdByte1),
    .cmdByte2    (cmdByte2),
    .cmdByte3    (cmdByte3),
    .homeModeCfg (homeModeCfg),
    .homeMode    (homeMode),
    .cmdTarget   (cmdTarget),
    .presentPos  (presentPos),
    .intDistance (intDistance),
    .moveTarget  (moveTarget)
);
